// [hdl/inverter_phase_firing_sequencer.sv]
// Inverter phase firing sequencer: divider, phase generator, PWM mux, protection
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "inv_seq_cfg.svh"

module inverter_phase_firing_sequencer
  import inv_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        oscPulse,
  input  wire logic        chopIn,
  input  wire logic        start_n,
  input  wire logic        reverse_request_n,
  input  wire logic        stopReset_n,
  input  wire logic        dcTrip,
  input  wire logic        instant_overcurrent,
  input  wire logic        overcurrent_limit_in,
  input  wire logic        overtemp_switch,
  input  wire logic        modulatorAtMin,
  output fire_t            fireOut,
  output logic      [2:0]  primary_trip_n,
  output logic             overcurrent_lockout_n,
  output logic             firing_train_n,
  output logic             min_voltage_n,
  output logic             run_n,
  output logic             freqFeedback,
  output logic             runningInd,
  output logic             resetRequired
);

  localparam int NPIN = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;

  assign pinRaw = {modulatorAtMin, overtemp_switch, overcurrent_limit_in, instant_overcurrent,
                   dcTrip, stopReset_n, reverse_request_n, start_n, chopIn, oscPulse};

  // Two flops per pin; only the second stage is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= pinRaw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic oscS, chopS, startReq, revReq, stopReq, atMin;
  fault_t faultIn;
  assign oscS     = sync2_ff[0];
  assign chopS    = sync2_ff[1];
  assign startReq = ~sync2_ff[2];
  assign revReq   = ~sync2_ff[3];
  assign stopReq  = ~sync2_ff[4];
  assign faultIn  = fault_t'(sync2_ff[8:5]);
  assign atMin    = sync2_ff[9];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, answer registered in the setup cycle
  logic [31:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] statusWord;
  logic        setupPh;
  logic        hitCtrl;
  logic        hitStat;

  assign setupPh = psel & ~penable;
  assign hitCtrl = (paddr == `ADDR_CTRL);
  assign hitStat = (paddr == `ADDR_STATUS);

  // Control word: bit 0 picks the divide-by-eight variant
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= `CTRL_RESET;
    else if (psel && penable && pready_ff && pwrite && hitCtrl)
      ctrl_ff <= {31'h0, pwdata[`CTRL_VAR8_BIT]};
  end

  // Read data and error latched at setup so access phase sees them at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setupPh;
      pslverr_ff <= setupPh & ~(hitCtrl | hitStat);
      if (setupPh && !pwrite)
        prdata_ff <= hitCtrl ? ctrl_ff : (hitStat ? statusWord : 32'h0);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator divider and frequency feedback
  logic       oscPrev_ff;
  logic [4:0] divCnt_ff;
  logic       stepTick_ff;
  logic       fb_ff;
  logic       oscEdge;
  logic [4:0] divMax;

  assign oscEdge = oscS & ~oscPrev_ff;
  assign divMax  = ctrl_ff[`CTRL_VAR8_BIT] ? `DIV_VAR8 : `DIV_VAR16;

  // One step tick per divMax oscillator pulses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oscPrev_ff  <= 1'b0;
      divCnt_ff   <= 5'h0;
      stepTick_ff <= 1'b0;
    end
    else
    begin
      oscPrev_ff  <= oscS;
      stepTick_ff <= 1'b0;
      if (oscEdge)
      begin
        if (divCnt_ff >= divMax - 5'h1)
        begin
          divCnt_ff   <= 5'h0;
          stepTick_ff <= 1'b1;
        end
        else
          divCnt_ff <= divCnt_ff + 5'h1;
      end
    end
  end

  // Feedback toggles per pulse, so it runs at half the oscillator rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fb_ff <= 1'b0;
    else if (oscEdge)
      fb_ff <= ~fb_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Six-step three-phase generator
  step_t step_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      step_ff <= S0;
    else if (stepTick_ff)
    begin
      unique case (step_ff)
        S0: step_ff <= S1;
        S1: step_ff <= S2;
        S2: step_ff <= S3;
        S3: step_ff <= S4;
        S4: step_ff <= S5;
        S5: step_ff <= S0;
        default: step_ff <= S0;
      endcase
    end
  end

  // Position of a phase within its own cycle, given its offset in steps
  function automatic logic [2:0] phaseIdx(input logic [2:0] st, input logic [2:0] off);
    logic [3:0] sum;
    sum = {1'b0, st} + {1'b0, `STEPS} - {1'b0, off};
    phaseIdx = (sum >= {1'b0, `STEPS}) ? 3'(sum - {1'b0, `STEPS}) : sum[2:0];
  endfunction : phaseIdx

  // Phases X, Y, Z sit 120 degrees apart; centre step is index 1 or 4
  logic [2:0] phHigh;
  logic [2:0] phCentre;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_phase
      logic [2:0] idx;
      assign idx          = phaseIdx(step_ff, 3'(2 * gi));
      assign phHigh[gi]   = (idx < 3'h3);
      assign phCentre[gi] = (idx == 3'h1) || (idx == 3'h4);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Direction: only changed while output voltage is at minimum
  logic dirRev_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dirRev_ff <= 1'b0;
    else if (atMin)
      dirRev_ff <= revReq;
  end

  // Route X to A always, Y/Z to B/C by direction
  logic [2:0] abcHigh;
  logic [2:0] abcCentre;
  assign abcHigh[0]   = phHigh[0];
  assign abcCentre[0] = phCentre[0];
  assign abcHigh[1]   = dirRev_ff ? phHigh[2] : phHigh[1];
  assign abcHigh[2]   = dirRev_ff ? phHigh[1] : phHigh[2];
  assign abcCentre[1] = dirRev_ff ? phCentre[2] : phCentre[1];
  assign abcCentre[2] = dirRev_ff ? phCentre[1] : phCentre[2];

  // Each leg is on in its half, chopped only in the centre step
  logic [2:0] legP;
  logic [2:0] legN;
  assign legP = abcHigh & (~abcCentre | {3{chopS}});
  assign legN = ~abcHigh & (~abcCentre | {3{chopS}});

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches: set wins over stop/reset clear
  fault_t faults_ff;
  logic   anyFault;
  logic   ocLock;

  assign anyFault = |faults_ff;
  assign ocLock   = faults_ff.instOc | faults_ff.overLimit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      faults_ff <= '0;
    else
      faults_ff <= fault_t'((faults_ff & {4{~stopReq}}) | faultIn);
  end

  // Start latch seals in; dropped by stop, any fault or over-temperature
  logic startLatch_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      startLatch_ff <= 1'b0;
    else if (stopReq || anyFault || (|faultIn) || faultIn.overTemp)
      startLatch_ff <= 1'b0;
    else if (startReq && atMin)
      startLatch_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Firing train: periodic low pulses while running
  logic [7:0] ftCnt_ff;
  logic       ft_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ftCnt_ff <= 8'h0;
      ft_ff    <= 1'b1;
    end
    else if (!startLatch_ff)
    begin
      ftCnt_ff <= 8'h0;
      ft_ff    <= 1'b1;
    end
    else
    begin
      ftCnt_ff <= (ftCnt_ff == 8'(`FT_PERIOD_CYC - 1)) ? 8'h0 : ftCnt_ff + 8'h1;
      ft_ff    <= ~(ftCnt_ff < 8'(`FT_LOW_CYC));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  fire_t fire_ff;
  logic [2:0] trip_ff;
  logic lock_ff, mv_ff, run_ff, runInd_ff, rstReq_ff;

  // Over-current fires every switch; otherwise gated by running state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fire_ff <= '0;
    else if (ocLock)
      fire_ff <= '1;
    else if (startLatch_ff && !anyFault)
      fire_ff <= '{a: legP[0], aN: legN[0], b: legP[1], bN: legN[1], c: legP[2], cN: legN[2]};
    else
      fire_ff <= '0;
  end

  // Status flags; a fault drops running and raises reset-required
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_ff   <= 3'h7;
      lock_ff   <= 1'b1;
      mv_ff     <= 1'b1;
      run_ff    <= 1'b1;
      runInd_ff <= 1'b0;
      rstReq_ff <= 1'b0;
    end
    else
    begin
      trip_ff   <= {3{~faults_ff.dcTrip}};
      lock_ff   <= ~ocLock;
      mv_ff     <= ~atMin;
      run_ff    <= ~(startLatch_ff & ~anyFault);
      runInd_ff <= startLatch_ff & ~anyFault;
      rstReq_ff <= anyFault;
    end
  end

  assign fireOut               = fire_ff;
  assign primary_trip_n        = trip_ff;
  assign overcurrent_lockout_n = lock_ff;
  assign firing_train_n        = ft_ff;
  assign min_voltage_n         = mv_ff;
  assign run_n                 = run_ff;
  assign freqFeedback          = fb_ff;
  assign runningInd            = runInd_ff;
  assign resetRequired         = rstReq_ff;

  // Status word for software, fault types readable before stop/reset
  assign statusWord = {21'h0, step_ff, startLatch_ff, dirRev_ff, faults_ff, rstReq_ff, runInd_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_DIV: assert property (@(posedge clk) disable iff (!rst_n)
    oscEdge && divCnt_ff == divMax - 5'h1 |=> stepTick_ff)
    else $error("divider tick missing");

  AST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    !stepTick_ff |=> $stable(step_ff))
    else $error("step moved without tick");

  AST_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
    (step_ff == S0) |-> phHigh == 3'b101)
    else $error("phase pattern wrong at step 0");

  AST_DIR: assert property (@(posedge clk) disable iff (!rst_n)
    dirRev_ff |-> abcHigh[1] == phHigh[2] && abcHigh[2] == phHigh[1])
    else $error("reverse swap wrong");

  AST_FB: assert property (@(posedge clk) disable iff (!rst_n)
    oscEdge |=> fb_ff != $past(fb_ff))
    else $error("feedback did not toggle");

  AST_TRIP: assert property (@(posedge clk) disable iff (!rst_n)
    faultIn.dcTrip |-> ##2 primary_trip_n == 3'h0)
    else $error("bus trip not issued");

  AST_IOC: assert property (@(posedge clk) disable iff (!rst_n)
    faultIn.instOc |-> ##2 fireOut == '1 && !overcurrent_lockout_n)
    else $error("over-current firing missing");

  AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    faults_ff.overLimit && !stopReq |=> faults_ff.overLimit)
    else $error("lockout released without reset");

  AST_SEAL: assert property (@(posedge clk) disable iff (!rst_n)
    startLatch_ff && !stopReq && !(|faultIn) |=> startLatch_ff)
    else $error("start latch dropped");

  AST_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    anyFault |=> resetRequired && !runningInd)
    else $error("fault indication wrong");

  AST_TEMP: assert property (@(posedge clk) disable iff (!rst_n)
    faultIn.overTemp |=> !startLatch_ff ##1 run_n)
    else $error("over-temperature did not stop");

  AST_MV: assert property (@(posedge clk) disable iff (!rst_n)
    !startLatch_ff && !atMin |=> !startLatch_ff)
    else $error("started away from minimum voltage");

  AST_FT: assert property (@(posedge clk) disable iff (!rst_n)
    startLatch_ff && ftCnt_ff == 8'h0 |=> !firing_train_n)
    else $error("firing train pulse missing");

  COV_RUN: cover property (@(posedge clk) disable iff (!rst_n) $fell(run_n));
  COV_REV: cover property (@(posedge clk) disable iff (!rst_n) runningInd && dirRev_ff && stepTick_ff);
  COV_IOC: cover property (@(posedge clk) disable iff (!rst_n) runningInd ##1 ocLock);
  COV_CLR: cover property (@(posedge clk) disable iff (!rst_n) resetRequired ##1 stopReq ##[1:4] !resetRequired);

endmodule : inverter_phase_firing_sequencer

// [hdl/inv_seq_cfg.svh]
// Constants for the inverter phase firing sequencer
`ifndef INV_SEQ_CFG_SVH
`define INV_SEQ_CFG_SVH
`define ADDR_CTRL      12'h000
`define ADDR_STATUS    12'h004
`define CTRL_VAR8_BIT  0
`define CTRL_RESET     32'h00000000
`define DIV_VAR16      5'h10
`define DIV_VAR8       5'h08
`define STEPS          3'h6
`define CLK_NS         4
`define FT_PERIOD_NS   200
`define FT_LOW_NS      20
`define FT_PERIOD_CYC  ((`FT_PERIOD_NS + `CLK_NS - 1) / `CLK_NS)
`define FT_LOW_CYC     ((`FT_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [hdl/inv_seq_pkg.sv]
// Types for the inverter phase firing sequencer
package inv_seq_pkg;
  typedef enum logic [2:0] {
    S0 = 3'b000, S1 = 3'b001, S2 = 3'b010,
    S3 = 3'b011, S4 = 3'b100, S5 = 3'b101
  } step_t;
  typedef struct packed {
    logic a;
    logic aN;
    logic b;
    logic bN;
    logic c;
    logic cN;
  } fire_t;
  typedef struct packed {
    logic overTemp;
    logic overLimit;
    logic instOc;
    logic dcTrip;
  } fault_t;
endpackage : inv_seq_pkg

// [tb/ref_source_model.sv]
// Reference source model that drives the oscillator pulse train
`timescale 1ns/1ps

module ref_source_model
(
  input  wire logic clk,
  output logic      oscPulse
);
  // Oscillator stands still, low, between bursts so each step is counted exactly
  initial oscPulse = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst of n pulses, two clocks high and two low, above the sync minimum
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk);
      oscPulse <= 1'b1;
      repeat (2) @(posedge clk);
      oscPulse <= 1'b0;
      @(posedge clk);
    end
  endtask : pulses
endmodule : ref_source_model

// [tb/inverter_phase_firing_sequencer_bench.sv]
// Self-checking bench for the inverter phase firing sequencer
`timescale 1ns/1ps
`include "inv_seq_cfg.svh"

module inverter_phase_firing_sequencer_bench
  import inv_seq_pkg::*;
;
  logic        clk               = 1'b0;
  logic        rst_n             = 1'b0;
  logic        psel              = 1'b0;
  logic        penable           = 1'b0;
  logic        pwrite            = 1'b0;
  logic [11:0] paddr             = 12'h000;
  logic [31:0] pwdata            = 32'h00000000;
  logic        chopIn            = 1'b1;
  logic        start_n           = 1'b1;
  logic        reverse_request_n = 1'b1;
  logic        stopReset_n       = 1'b1;
  logic        modulatorAtMin    = 1'b1;
  logic [3:0]  faultPins         = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        oscPulse;
  fire_t       fireOut;
  logic [2:0]  primary_trip_n;
  logic        lockout_n;
  logic        firing_train_n;
  logic        min_voltage_n;
  logic        run_n;
  logic        freqFeedback;
  logic        runningInd;
  logic        resetRequired;
  logic        ffPrev            = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          badCount          = 0;
  int          samplesChecked    = 0;
  int          cycles            = 0;
  int          ffToggles         = 0;
  int          lows;
  int          n;
  logic [2:0]  step;

  always #2 clk = ~clk;

  ref_source_model src (.clk(clk), .oscPulse(oscPulse));

  inverter_phase_firing_sequencer dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscPulse(oscPulse),
    .chopIn(chopIn), .start_n(start_n), .reverse_request_n(reverse_request_n), .stopReset_n(stopReset_n),
    .dcTrip(faultPins[0]), .instant_overcurrent(faultPins[1]), .overcurrent_limit_in(faultPins[2]),
    .overtemp_switch(faultPins[3]), .modulatorAtMin(modulatorAtMin), .fireOut(fireOut),
    .primary_trip_n(primary_trip_n), .overcurrent_lockout_n(lockout_n), .firing_train_n(firing_train_n),
    .min_voltage_n(min_voltage_n), .run_n(run_n), .freqFeedback(freqFeedback), .runningInd(runningInd),
    .resetRequired(resetRequired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Feedback toggle counter and hang guard; ceiling is about twenty times the run length
  always @(posedge clk)
  begin
    ffPrev <= freqFeedback;
    if (freqFeedback !== ffPrev) ffToggles++;
    cycles++;
    if (cycles == 30000)
    begin
      badCount++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic waitClk(input int k);
    repeat (k) @(posedge clk);
  endtask : waitClk

  // Holds the request until pready is seen high at an edge; bounded wait.
  // Outputs are looked at mid-cycle, where they are settled for the coming edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1 && w < 20)
    begin
      w++;
      @(negedge clk);
    end
    if (w == 20) chk(32'h0, 32'h1, "bus answer");
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start request is released again; the latch must carry the run on its own
  task automatic doStart;
    start_n <= 1'b0;
    waitClk(3);
    start_n <= 1'b1;
    waitClk(6);
  endtask : doStart

  task automatic stopPulse;
    stopReset_n <= 1'b0;
    waitClk(4);
    stopReset_n <= 1'b1;
    waitClk(6);
  endtask : stopPulse

  task automatic ftLows(output int c);
    c = 0;
    repeat (2 * `FT_PERIOD_CYC)
    begin
      @(posedge clk);
      if (firing_train_n === 1'b0) c++;
    end
  endtask : ftLows

  // One leg {high, low} of a phase with offset o; centre steps follow the chop level
  function automatic logic [1:0] leg(input int s, input int o, input logic ch);
    int p;
    p = (s - o + 6) % 6;
    return {(p < 3) && (p != 1 || ch), (p >= 3) && (p != 4 || ch)};
  endfunction : leg

  function automatic logic [5:0] expFire(input int s, input logic rev, input logic ch);
    return rev ? {leg(s, 0, ch), leg(s, 4, ch), leg(s, 2, ch)} : {leg(s, 0, ch), leg(s, 2, ch), leg(s, 4, ch)};
  endfunction : expFire

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    waitClk(5);
    chk(32'(fireOut), 32'h0, "fire in reset");
    chk(32'({primary_trip_n, lockout_n, firing_train_n, run_n}), 32'h3f, "idle levels in reset");
    waitClk(5);
    rst_n <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd, `CTRL_RESET, "ctrl reset");
    apb(1'b1, `ADDR_CTRL, 32'h1);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd, 32'h1, "ctrl divide select");
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("Test registers done");
    // Start is refused away from minimum voltage
    modulatorAtMin <= 1'b0;
    doStart();
    chk(32'(runningInd), 32'h0, "start refused");
    chk(32'(min_voltage_n), 32'h1, "min flag off");
    modulatorAtMin <= 1'b1;
    waitClk(6);
    chk(32'(min_voltage_n), 32'h0, "min flag on");
    doStart();
    chk(32'({run_n, runningInd}), 32'h1, "run after start");
    ftLows(lows);
    chk(lows, 2 * `FT_LOW_CYC, "firing train lows");
    $display("Test start done");
    for (int r = 0; r < 2; r++)
    begin
      reverse_request_n <= ~r[0];
      for (int k = 0; k < 6; k++)
      begin
        chopIn <= k[0];
        n = (k < 4) ? 16 : 8;
        apb(1'b1, `ADDR_CTRL, (k < 4) ? 32'h0 : 32'h1);
        waitClk(6);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        step = rd[10:8];
        chk(rd[6], r, "direction");
        chk(32'(fireOut), 32'(expFire(step, r[0], k[0])), "phase pattern");
        lows = ffToggles;
        src.pulses(n);
        waitClk(6);
        chk(ffToggles - lows, n, "feedback toggles");
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk(rd[10:8], (step + 1) % 6, "step advance");
      end
    end
    $display("Test phases done");
    stopPulse();
    ftLows(lows);
    chk({lows[30:0], runningInd}, 32'h0, "stopped");
    $display("Test stop done");
    for (int i = 0; i < 4; i++)
    begin
      doStart();
      faultPins <= 4'(1 << i);
      waitClk(3);
      faultPins <= 4'h0;
      waitClk(8);
      chk(32'({runningInd, resetRequired}), 32'h1, "fault indication");
      if (i == 0) chk(32'(primary_trip_n), 32'h0, "bus trip");
      if (i == 1 || i == 2) chk(32'({fireOut, lockout_n}), 32'h7e, "all fire, lockout");
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd[5:2], 32'(1 << i), "fault type");
      if (i == 3) chk(rd[7], 32'h0, "latch dropped");
      stopPulse();
      chk(32'({resetRequired, primary_trip_n, lockout_n}), 32'hf, "fault cleared");
    end
    $display("Test faults done");
    end_of_test();
  end
endmodule : inverter_phase_firing_sequencer_bench
